// ### hw/dither_trim_defs.svh
/*
  Offsets, field widths, reset values and scaling constants for the
  dither and offset trim register bank.
  Assumes inclusion from the package and the bank module only.
*/
// Overview of operation
// - Keep a writable right secondary dither amount; add it to modulator low bits.
// - Dither amount is unsigned Q0.11; one equals 1/32 of modulator full scale.
// - Code zero adds nothing; bit 0 weighs 2^-11, bit 1 weighs 2^-10 of 1/32 FS.
// - Keep 8-bit left offset trim; apply it as manual DC offset on left output.
// - Keep 8-bit right offset trim; apply it as manual DC offset on right output.
// - Applied offset is the negated signed trim divided by four, in millivolts.
// - Trim is two's complement: 0x7F gives -31.75 mV, 0x80 gives +32.0 mV.
`ifndef DITHER_TRIM_DEFS_SVH
`define DITHER_TRIM_DEFS_SVH

`define OFS_DITHER_A      8'h4B
`define OFS_DITHER_B      8'h4C
`define OFS_LEFT_TRIM     8'h4E
`define OFS_RIGHT_TRIM    8'h4F
`define RST_REG           8'h00
`define DITHER_FRAC_BITS  11
`define DITHER_WIDTH      11
`define TRIM_WIDTH        8
`define OFFSET_QMV_WIDTH  9

`endif

// ### hw/dither_trim_pkg.sv
/*
  Types for the dither and offset trim register bank.
  Assumes the constants header is on the include path.
*/
`include "dither_trim_defs.svh"

package dither_trim_pkg;

  // Host register access, one byte per transaction
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Applied offsets in quarter millivolts, signed
  typedef struct packed {
    logic signed [`OFFSET_QMV_WIDTH-1:0] left_qmv;
    logic signed [`OFFSET_QMV_WIDTH-1:0] right_qmv;
  } offset_out_t;

endpackage : dither_trim_pkg

// ### hw/dac_dither_offset_trim_regs.sv
/*
  Register bank holding the right secondary DC dither amount and the left
  and right manual offset trims, with their drive to the modulator and the
  offset stage.
  Assumes the control port decoder hands in single-cycle byte requests on
  clk, and that the modulator adds dither_q0_11 to its low-order input bits.
*/
`timescale 1ns/10ps
`default_nettype none

`include "dither_trim_defs.svh"

module dac_dither_offset_trim_regs
  import dither_trim_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Control port register access
  input  wire reg_req_t                      req,
  output logic      [7:0]                    rdata,
  output logic                               rvalid,
  // Modulator and offset stage
  output logic      [`DITHER_WIDTH-1:0]      dither_q0_11,
  output logic                               dither_active,
  output logic      [`TRIM_WIDTH-1:0]        left_offset_trim_value,
  output logic      [`TRIM_WIDTH-1:0]        right_offset_trim_value,
  output offset_out_t                        offset_qmv
);

  logic [7:0]        dither_a;
  logic [7:0]        dither_b;
  logic [7:0]        left_trim;
  logic [7:0]        right_trim;
  logic [7:0]        next_dither_a;
  logic [7:0]        next_dither_b;
  logic [7:0]        next_left_trim;
  logic [7:0]        next_right_trim;
  logic [7:0]        next_rdata;
  logic              next_rvalid;
  logic [`DITHER_WIDTH-1:0] next_dither;
  logic              next_dither_active;
  offset_out_t       next_offset;

  // Register writes and read mux
  always_comb begin
    next_dither_a   = dither_a;
    next_dither_b   = dither_b;
    next_left_trim  = left_trim;
    next_right_trim = right_trim;
    if (req.wr) begin
      case (req.addr)
        `OFS_DITHER_A:   next_dither_a   = req.wdata;
        `OFS_DITHER_B:   next_dither_b   = req.wdata;
        `OFS_LEFT_TRIM:  next_left_trim  = req.wdata;
        `OFS_RIGHT_TRIM: next_right_trim = req.wdata;
        default:         ;
      endcase
    end
    next_rvalid = req.rd;
    case (req.addr)
      `OFS_DITHER_A:   next_rdata = dither_a;
      `OFS_DITHER_B:   next_rdata = dither_b;
      `OFS_LEFT_TRIM:  next_rdata = left_trim;
      `OFS_RIGHT_TRIM: next_rdata = right_trim;
      default:         next_rdata = 8'h00;
    endcase
    if (!req.rd) begin
      next_rdata = 8'h00;
    end
  end

  // Dither: low byte plus the three low bits of part b form the Q0.11 code.
  // Upper five bits of part b are stored for read-back but do not steer.
  always_comb begin
    next_dither        = {dither_b[2:0], dither_a};
    next_dither_active = (next_dither != '0);
  end

  // Offset in quarter mV is the negated signed trim; 0x80 negates to +128
  // which needs the ninth bit, so the sign is extended before negating.
  always_comb begin
    next_offset.left_qmv  = -$signed({left_trim[7], left_trim});
    next_offset.right_qmv = -$signed({right_trim[7], right_trim});
  end

  // Register file
  always_ff @(posedge clk) begin
    if (rst) begin
      dither_a   <= `RST_REG;
      dither_b   <= `RST_REG;
      left_trim  <= `RST_REG;
      right_trim <= `RST_REG;
    end else begin
      dither_a   <= next_dither_a;
      dither_b   <= next_dither_b;
      left_trim  <= next_left_trim;
      right_trim <= next_right_trim;
    end
  end

  // Read port
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Drive to modulator and offset stage, one edge behind the registers
  always_ff @(posedge clk) begin
    if (rst) begin
      dither_q0_11            <= '0;
      dither_active           <= 1'b0;
      left_offset_trim_value  <= '0;
      right_offset_trim_value <= '0;
      offset_qmv              <= '0;
    end else begin
      dither_q0_11            <= next_dither;
      dither_active           <= next_dither_active;
      left_offset_trim_value  <= left_trim;
      right_offset_trim_value <= right_trim;
      offset_qmv              <= next_offset;
    end
  end

  a_read_back: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.addr == `OFS_LEFT_TRIM) ##1
    (req.rd && req.addr == `OFS_LEFT_TRIM && !req.wr) |=> rdata == $past(req.wdata, 2))
    else $error("left trim read-back mismatch");

  a_reset_zero: assert property (@(posedge clk)
    $past(rst) |-> (left_trim == 8'h00 && dither_a == 8'h00 &&
                    right_trim == 8'h00 && dither_b == 8'h00))
    else $error("registers not zero after reset");

  a_dither_map: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> dither_q0_11 == {$past(dither_b[2:0]), $past(dither_a)})
    else $error("dither code not built from both parts");

  a_dither_zero: assert property (@(posedge clk) disable iff (rst)
    ##1 (dither_active == (dither_q0_11 != '0)))
    else $error("dither active flag wrong for code");

  a_dither_lsb: assert property (@(posedge clk) disable iff (rst)
    (dither_a == 8'h01 && dither_b[2:0] == 3'b000) |=> dither_q0_11 == 11'h001)
    else $error("dither lsb weight wrong");

  a_left_trim_out: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> left_offset_trim_value == $past(left_trim))
    else $error("left trim not driven to offset stage");

  a_right_trim_out: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> right_offset_trim_value == $past(right_trim))
    else $error("right trim not driven to offset stage");

  a_offset_neg: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> offset_qmv.left_qmv + $signed({$past(left_trim[7]), $past(left_trim)}) == 9'sd0)
    else $error("left offset is not the negated trim");

  a_offset_ends: assert property (@(posedge clk) disable iff (rst)
    (right_trim == 8'h80) |=> offset_qmv.right_qmv == 9'sd128)
    else $error("most negative trim must give plus 32 mV");

  a_dither_low_write: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.addr == `OFS_DITHER_A) |=> dither_a == $past(req.wdata))
    else $error("dither part a write did not land");

  a_dither_high_write: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.addr == `OFS_DITHER_B) |=> dither_b == $past(req.wdata))
    else $error("dither part b write did not land");

  a_left_trim_write: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.addr == `OFS_LEFT_TRIM) |=> left_trim == $past(req.wdata))
    else $error("left trim write did not land");

  a_right_trim_write: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.addr == `OFS_RIGHT_TRIM) |=> right_trim == $past(req.wdata))
    else $error("right trim write did not land");

  a_dither_high_bits: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.addr == `OFS_DITHER_B) |=>
    ##1 dither_q0_11[10:8] == $past(req.wdata[2:0], 2))
    else $error("dither high bits not taken from part b");

  a_read_valid: assert property (@(posedge clk) disable iff (rst)
    req.rd |=> rvalid)
    else $error("read not answered on the next edge");

  a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
    !req.rd |=> (!rvalid && rdata == 8'h00))
    else $error("read port not quiet without a read");

  a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    (req.rd && !(req.addr inside {`OFS_DITHER_A, `OFS_DITHER_B, `OFS_LEFT_TRIM,
                                  `OFS_RIGHT_TRIM})) |=> (rvalid && rdata == 8'h00))
    else $error("unmapped read returned data");

  a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
    (req.wr && !(req.addr inside {`OFS_DITHER_A, `OFS_DITHER_B, `OFS_LEFT_TRIM,
                                  `OFS_RIGHT_TRIM})) |=>
    ($stable(dither_a) && $stable(dither_b) && $stable(left_trim) && $stable(right_trim)))
    else $error("unmapped write changed a register");

  a_trim_hold: assert property (@(posedge clk) disable iff (rst)
    !(req.wr && req.addr == `OFS_LEFT_TRIM) |=> $stable(left_trim))
    else $error("left trim changed without a write");

  a_offset_neg_right: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> offset_qmv.right_qmv + $signed({$past(right_trim[7]), $past(right_trim)}) == 9'sd0)
    else $error("right offset is not the negated trim");

  a_offset_left_max: assert property (@(posedge clk) disable iff (rst)
    (left_trim == 8'h7F) |=> offset_qmv.left_qmv == 9'h181)
    else $error("largest positive trim gives wrong offset");

  a_offset_left_top: assert property (@(posedge clk) disable iff (rst)
    (left_trim == 8'h80) |=> offset_qmv.left_qmv == 9'h080)
    else $error("most negative left trim gives wrong offset");

  a_offset_minus_one: assert property (@(posedge clk) disable iff (rst)
    (left_trim == 8'hFF) |=> offset_qmv.left_qmv == 9'h001)
    else $error("all ones trim must give one quarter step up");

  a_offset_zero: assert property (@(posedge clk) disable iff (rst)
    (left_trim == 8'h00) |=> offset_qmv.left_qmv == 9'h000)
    else $error("zero trim must give no offset");

  a_reset_outputs: assert property (@(posedge clk)
    rst |=> (rdata == 8'h00 && !rvalid && dither_q0_11 == '0 && !dither_active &&
             left_offset_trim_value == 8'h00 && right_offset_trim_value == 8'h00 &&
             offset_qmv == '0))
    else $error("outputs not cleared by reset");

endmodule : dac_dither_offset_trim_regs

`default_nettype wire

// ### verification/host_port_model.sv
/* Host side of the control port: single byte writes and reads.
   Assumes the bank shares clk and answers a read one edge later. */
`timescale 1ns/10ps
`default_nettype none
module host_port_model
  import dither_trim_pkg::*;
(
  // Bank control port
  input  wire logic       clk,
  output var  reg_req_t   req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;
  // Idle bus shows inverted leftovers, not stale data
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  // Write then read the same register, in one cycle or on the next one
  task automatic wr_rd(input logic [7:0] a, d, input logic same, output logic [7:0] q);
    @(posedge clk) #1 req = '{1'b1, same, a, d};
    if (!same) begin
      @(posedge clk) #1 req = '{1'b0, 1'b1, a, ~d};
    end
    @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, ~d};
    q = rdata;
  endtask : wr_rd
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk) #1 req = '{1'b0, 1'b1, a, ~a};
    @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, a};
    d = rdata;
    v = rvalid;
  endtask : rd
endmodule : host_port_model
`default_nettype wire

// ### verification/dac_dither_offset_trim_regs_bench.sv
/* Bench for the dither and trim bank: reset values, trims, dither code,
   unmapped access. Assumes the host model drives the control port. */
`timescale 1ns/10ps
`default_nettype none
module dac_dither_offset_trim_regs_bench import dither_trim_pkg::*;;
  logic              clk;
  logic              rst;
  reg_req_t          req;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [10:0]       dq;
  logic              da;
  logic [7:0]        lt;
  logic [7:0]        rt;
  offset_out_t       oq;
  logic [7:0]        d;
  logic [8:0]        exp_left [5]  = '{9'h181, 9'h000, 9'h001, 9'h080, 9'h1FF};
  logic [8:0]        exp_right [5] = '{9'h080, 9'h001, 9'h000, 9'h181, 9'h002};
  int                mismatches = 0;
  int                comparisons = 0;
  logic [7:0]        codes [5] = '{8'h7F, 8'h00, 8'hFF, 8'h80, 8'h01};
  logic [7:0]        addrs [4] = '{8'h4B, 8'h4C, 8'h4E, 8'h4F};
  dac_dither_offset_trim_regs DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .dither_q0_11(dq), .dither_active(da),
    .left_offset_trim_value(lt), .right_offset_trim_value(rt), .offset_qmv(oq));
  host_port_model H (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  task automatic chk(input string n, input logic [10:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    logic       v;
    H.rd(a, d, v);
    chk("rvalid", 11'h001, {10'b0, v});
    chk("rdata", {3'b0, e}, {3'b0, d});
  endtask : rd
  // Derived outputs land one edge after the write edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    mismatches++;
    results();
  end
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    chk("dither", 11'h000, dq);
    chk("active", 11'h000, {10'b0, da});
    foreach (codes[i]) begin
      H.wr(8'h4E, codes[i]);
      H.wr(8'h4F, ~codes[i]);
      settle();
      chk("left_trim", {3'b0, codes[i]}, {3'b0, lt});
      chk("right_trim", {3'b0, ~codes[i]}, {3'b0, rt});
      chk("left_qmv", {2'b0, exp_left[i]}, {2'b0, oq.left_qmv});
      chk("right_qmv", {2'b0, exp_right[i]}, {2'b0, oq.right_qmv});
      rd(8'h4E, codes[i]);
      rd(8'h4F, ~codes[i]);
    end
    H.wr(8'h4B, 8'h01);
    settle();
    chk("dither", 11'h001, dq);
    chk("active", 11'h001, {10'b0, da});
    H.wr(8'h4B, 8'h02);
    settle();
    chk("dither", 11'h002, dq);
    H.wr(8'h4C, 8'hFF);
    settle();
    chk("dither", 11'h702, dq);
    rd(8'h4C, 8'hFF);
    H.wr(8'h4D, 8'h55);
    rd(8'h4D, 8'h00);
    rd(8'h4E, 8'h01);
    H.wr(8'h4B, 8'h00);
    H.wr(8'h4C, 8'hF8);
    settle();
    chk("dither", 11'h000, dq);
    chk("active", 11'h000, {10'b0, da});
    rd(8'h4C, 8'hF8);
    H.wr_rd(8'h4E, 8'h5A, 1'b1, d);
    chk("rdata_same", 11'h001, {3'b0, d});
    H.wr_rd(8'h4E, 8'hA5, 1'b0, d);
    chk("rdata_next", 11'h0A5, {3'b0, d});
    // Second reset in mid-run must clear what was written
    @(posedge clk) #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    chk("left_trim", 11'h000, {3'b0, lt});
    chk("left_qmv", 11'h000, {2'b0, oq.left_qmv});
    results();
  end
endmodule : dac_dither_offset_trim_regs_bench
`default_nettype wire
